// ---- hw/tpu_top.sv ----
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "tpu_regs.svh"
module tpu_top (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire tpu_pkg::tpu_apb_s  apb,
  input  wire logic [7:0]         cap_pin,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [6:1]              pwm_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // word index of an address inside a register bank
  function automatic logic [2:0] widx(input logic [7:0] a,
                                      input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[4:2];
  endfunction

  // combine the two pins that feed one capture channel
  function automatic logic pick(input logic [1:0] pins,
                                input logic [1:0] mask,
                                input logic       andm);
    logic r;
    if (andm) begin
      r = (&(pins | ~mask)) & (|mask);
    end else begin
      r = |(pins & mask);
    end
    return r;
  endfunction

  // read decode: bit 32 says the address is mapped
  function automatic logic [32:0] rd(input tpu_pkg::tpu_state_s st,
                                     input logic [11:0] ad);
    logic [32:0] r;
    logic [7:0]  a;
    r = {1'b1, `TPU_RST_W};
    a = ad[7:0];
    case (a)
      `TPU_A_FLAG: r[31:0] = 32'(st.flags);
      `TPU_A_CTRL: r[31:0] = 32'(st.ctrl);
      `TPU_A_TC:   r[31:0] = st.tc;
      `TPU_A_PR:   r[31:0] = st.pr;
      `TPU_A_PC:   r[31:0] = st.pc;
      `TPU_A_MCR:  r[31:0] = 32'(st.mcr);
      `TPU_A_CCR:  r[31:0] = 32'(st.ccr);
      `TPU_A_EMR:  r[31:0] = 32'(st.emr);
      `TPU_A_PCR:  r[31:0] = 32'(st.pcr);
      `TPU_A_LER:  r[31:0] = 32'(st.ler);
      `TPU_A_CSEL: r[31:0] = 32'(st.csel);
      default: begin
        // software sees the value it wrote, not the live one
        if (a >= `TPU_A_MATCH0 && a <= `TPU_A_MATCH6) begin
          r[31:0] = st.sh[widx(a, `TPU_A_MATCH0)];
        end else if (a >= `TPU_A_CR0 && a <= `TPU_A_CR3) begin
          r[31:0] = st.cap[widx(a, `TPU_A_CR0)];
        end else begin
          r[32] = 1'b0;
        end
      end
    endcase
    // unaligned or high addresses are unmapped
    if (ad[11:8] != 4'h0 || ad[1:0] != 2'h0) begin
      r = {1'b0, `TPU_RST_W};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and per-cycle events

  tpu_pkg::tpu_state_s s_reg;    // registered state
  tpu_pkg::tpu_state_s s_next;   // next state
  logic                tick;     // prescaler wrapped this cycle
  logic [6:0]          hit;      // match events on this tick
  logic                rst_any;  // some match resets the counter
  logic                stop_any; // some match stops the counter
  logic [3:0]          cnow;     // combined capture inputs
  logic [3:0]          cev;      // capture events
  logic [11:0]         fset;     // flags set by hardware
  logic                wr;       // apb write in access phase
  logic                pwm;      // pwm mode enabled
  logic [32:0]         rdv;      // read decode result

  assign pwm = s_reg.ctrl[`TPU_CT_PWM];
  assign wr  = apb.psel & apb.penable & s_reg.pready & apb.pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // the whole unit in one process so every field sees the same events
  always_comb begin
    s_next   = s_reg;
    tick     = 1'b0;
    hit      = 7'h00;
    rst_any  = 1'b0;
    stop_any = 1'b0;
    cnow     = 4'h0;
    cev      = 4'h0;
    fset     = 12'h000;
    rdv      = rd(s_reg, apb.paddr);

    // apb: answer one cycle after setup, never a wait state
    s_next.pready  = apb.psel & ~apb.penable;
    s_next.pslverr = apb.psel & ~apb.penable & ~rdv[32];
    if (apb.psel & ~apb.penable) begin
      s_next.prdata = rdv[31:0];
    end

    // capture pins: two flops, then the combining logic
    s_next.sync1 = cap_pin;
    s_next.sync2 = s_reg.sync1;
    for (int j = 0; j < 4; j++) begin
      // each channel sees only its own pin pair, pins 2j and 2j+1, so no pin feeds two channels
      cnow[j] = pick(s_reg.sync2[2*j +: 2],
                     s_reg.csel[2*j +: 2],
                     s_reg.csel[`TPU_CS_AND + j]);
    end
    s_next.cprev = cnow;

    // prescaler and counter
    if (s_reg.ctrl[`TPU_CT_RST]) begin
      // held in reset by software
      s_next.tc = `TPU_RST_W;
      s_next.pc = `TPU_RST_W;
    end else if (s_reg.ctrl[`TPU_CT_EN]) begin
      if (s_reg.pc == s_reg.pr) begin
        tick      = 1'b1;
        s_next.pc = `TPU_RST_W;
      end else begin
        s_next.pc = s_reg.pc + `TPU_ONE;
      end
    end

    if (tick) begin
      // compare all seven matches on the prescaled tick
      for (int i = 0; i < 7; i++) begin
        hit[i] = (s_reg.tc == s_reg.mr[i]);
        if (hit[i]) begin
          rst_any  = rst_any | s_reg.mcr[`TPU_MC_W*i + `TPU_MC_RST];
          stop_any = stop_any | s_reg.mcr[`TPU_MC_W*i + `TPU_MC_STOP];
          fset[i]  = s_reg.mcr[`TPU_MC_W*i + `TPU_MC_INT];
        end
      end
      // in pwm mode the period match always restarts the cycle
      rst_any = rst_any | (pwm & hit[0]);
      if (rst_any) begin
        s_next.tc = `TPU_RST_W;
      end else if (stop_any) begin
        // a stop match leaves the counter on the matched value, so software
        // reads back exactly where it halted
        s_next.tc = s_reg.tc;
      end else begin
        s_next.tc = s_reg.tc + `TPU_ONE;
      end
      if (stop_any) begin
        s_next.ctrl[`TPU_CT_EN] = 1'b0;
      end
    end

    // external match outputs stay internal, reached only through the EMR register
    for (int i = 0; i < 4; i++) begin
      if (hit[i]) begin
        case (s_reg.emr[`TPU_EM_CTL + 2*i +: 2])
          `TPU_EM_LOW:  s_next.emr[i] = 1'b0;
          `TPU_EM_HIGH: s_next.emr[i] = 1'b1;
          `TPU_EM_TGL:  s_next.emr[i] = ~s_reg.emr[i];
          default:      s_next.emr[i] = s_reg.emr[i];
        endcase
      end
    end

    // pulse outputs: n sets on period or on match n-1, clears on n
    for (int k = 1; k < 7; k++) begin
      if (pwm & s_reg.pcr[`TPU_PC_ENA + k]) begin
        if (s_reg.pcr[k]) begin
          // double edge: rise at k-1, fall at k; order gives polarity
          if (hit[k-1]) begin
            s_next.out[k] = 1'b1;
          end
        end else if (hit[0]) begin
          s_next.out[k] = 1'b1;
        end
        if (hit[k]) begin
          // fall wins when both edges meet, giving constant low
          s_next.out[k] = 1'b0;
        end
      end else begin
        s_next.out[k] = 1'b0;
      end
    end

    // released shadows go live only at the start of a cycle
    if (pwm & hit[0]) begin
      for (int i = 0; i < 7; i++) begin
        if (s_reg.ler[i]) begin
          s_next.mr[i]  = s_reg.sh[i];
          s_next.ler[i] = 1'b0;
        end
      end
    end

    // captures latch the counter on selected edges
    for (int j = 0; j < 4; j++) begin
      cev[j] = (s_reg.ccr[`TPU_CC_W*j + `TPU_CC_RISE] & cnow[j] & ~s_reg.cprev[j]) |
               (s_reg.ccr[`TPU_CC_W*j + `TPU_CC_FALL] & ~cnow[j] & s_reg.cprev[j]);
      if (cev[j]) begin
        s_next.cap[j] = s_reg.tc;
        fset[`TPU_FL_CAP + j] = s_reg.ccr[`TPU_CC_W*j + `TPU_CC_INT];
      end
    end

    // register writes; applied after hardware so software wins on data
    if (wr & rdv[32]) begin
      case (apb.paddr[7:0])
        `TPU_A_FLAG: s_next.flags = s_reg.flags & ~apb.pwdata[11:0];
        `TPU_A_CTRL: s_next.ctrl  = apb.pwdata[3:0];
        `TPU_A_TC:   s_next.tc    = apb.pwdata;
        `TPU_A_PR:   s_next.pr    = apb.pwdata;
        `TPU_A_PC:   s_next.pc    = apb.pwdata;
        `TPU_A_MCR:  s_next.mcr   = apb.pwdata[20:0];
        `TPU_A_CCR:  s_next.ccr   = apb.pwdata[11:0];
        `TPU_A_EMR:  s_next.emr   = apb.pwdata[11:0];
        `TPU_A_PCR:  s_next.pcr   = apb.pwdata[14:0];
        `TPU_A_LER:  s_next.ler   = apb.pwdata[6:0];
        `TPU_A_CSEL: s_next.csel  = apb.pwdata[11:0];
        default: begin
          if (apb.paddr[7:0] >= `TPU_A_MATCH0 &&
              apb.paddr[7:0] <= `TPU_A_MATCH6) begin
            s_next.sh[widx(apb.paddr[7:0], `TPU_A_MATCH0)] = apb.pwdata;
            // a plain timer has no update hazard, so write through
            if (!pwm) begin
              s_next.mr[widx(apb.paddr[7:0], `TPU_A_MATCH0)] = apb.pwdata;
            end
          end
        end
      endcase
    end

    // an event in the clearing cycle survives the clear
    s_next.flags = s_next.flags | fset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // synchronous reset leaves counting stopped
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // the pulse outputs and the apb response leave the block; external match bits do not
  assign pwm_out = s_reg.out;
  assign prdata  = s_reg.prdata;
  assign pready  = s_reg.pready;
  assign pslverr = s_reg.pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_period_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (tick & pwm & hit[0] & ~wr) |=> (s_reg.tc == `TPU_RST_W))
    else $error("period match did not restart the counter");

  a_prescale_hold: assert property (@(posedge clk) disable iff (!rstn)
    (s_reg.ctrl[`TPU_CT_EN] & ~s_reg.ctrl[`TPU_CT_RST] &
     (s_reg.pc != s_reg.pr) & ~wr) |=> $stable(s_reg.tc))
    else $error("counter moved before the prescaler wrapped");

  a_tc_advance: assert property (@(posedge clk) disable iff (!rstn)
    (tick & ~rst_any & ~stop_any & ~wr) |=> (s_reg.tc == $past(s_reg.tc) + `TPU_ONE))
    else $error("counter did not advance by one on a tick");

  a_single_rise: assert property (@(posedge clk) disable iff (!rstn)
    (pwm & s_reg.pcr[`TPU_PC_ENA + 1] & ~s_reg.pcr[1] & hit[0] & ~hit[1] & ~wr)
    |=> pwm_out[1])
    else $error("single edge output missed its rise");

  a_single_fall: assert property (@(posedge clk) disable iff (!rstn)
    (pwm & s_reg.pcr[`TPU_PC_ENA + 1] & hit[1] & ~wr) |=> ##[0:1] !pwm_out[1])
    else $error("single edge output missed its fall");

  a_double_rise: assert property (@(posedge clk) disable iff (!rstn)
    (pwm & s_reg.pcr[`TPU_PC_ENA + 3] & s_reg.pcr[3] & hit[2] & ~hit[3] & ~wr)
    |=> pwm_out[3])
    else $error("double edge output missed its rise");

  a_match_hold: assert property (@(posedge clk) disable iff (!rstn)
    (pwm & ~hit[0]) |=> (s_reg.mr == $past(s_reg.mr)))
    else $error("live match changed outside the period match");

  a_stop_match: assert property (@(posedge clk) disable iff (!rstn)
    (stop_any & ~wr) |=> !s_reg.ctrl[`TPU_CT_EN])
    else $error("stop on match did not halt counting");

  a_capture_latch: assert property (@(posedge clk) disable iff (!rstn)
    cev[0] |=> (s_reg.cap[0] == $past(s_reg.tc)))
    else $error("capture did not latch the counter");

  a_stop_hold: assert property (@(posedge clk) disable iff (!rstn)
    (stop_any & ~rst_any & ~wr) |=> $stable(s_reg.tc))
    else $error("stop on match moved the counter");

  a_pins_idle: assert property (@(posedge clk) disable iff (!rstn)
    !pwm |=> (pwm_out == 6'h00))
    else $error("pulse output active outside pwm mode");

  a_release_clear: assert property (@(posedge clk) disable iff (!rstn)
    (pwm & hit[0] & ~wr) |=> (s_reg.ler == 7'h00))
    else $error("released match values stayed pending");

  a_match_flag: assert property (@(posedge clk) disable iff (!rstn)
    (hit[1] & s_reg.mcr[`TPU_MC_W + `TPU_MC_INT]) |=> s_reg.flags[1])
    else $error("match with interrupt enabled left its flag clear");

endmodule

// ---- hw/tpu_regs.svh ----
`ifndef TPU_REGS_SVH
`define TPU_REGS_SVH
// register byte offsets
`define TPU_A_FLAG 8'h00
`define TPU_A_CTRL 8'h04
`define TPU_A_TC   8'h08
`define TPU_A_PR   8'h0c
`define TPU_A_PC   8'h10
`define TPU_A_MCR  8'h14
`define TPU_A_MATCH0 8'h18
`define TPU_A_MATCH6 8'h30
`define TPU_A_CCR  8'h34
`define TPU_A_CR0  8'h38
`define TPU_A_CR3  8'h44
`define TPU_A_EMR  8'h48
`define TPU_A_PCR  8'h4c
`define TPU_A_LER  8'h50
`define TPU_A_CSEL 8'h54
// control bits
`define TPU_CT_EN  0
`define TPU_CT_RST 1
`define TPU_CT_PWM 3
// match control: three bits per match
`define TPU_MC_W    3
`define TPU_MC_INT  0
`define TPU_MC_RST  1
`define TPU_MC_STOP 2
// capture control: three bits per channel
`define TPU_CC_RISE 0
`define TPU_CC_FALL 1
`define TPU_CC_INT  2
`define TPU_CC_W    3
// flag, pwm control, capture select and external match layouts
`define TPU_FL_CAP  8
`define TPU_PC_ENA  8
`define TPU_CS_AND  8
`define TPU_EM_CTL  4
// external match actions
`define TPU_EM_LOW  2'h1
`define TPU_EM_HIGH 2'h2
`define TPU_EM_TGL  2'h3
// reset value and count step
`define TPU_RST_W   32'h0000_0000
`define TPU_ONE     32'h0000_0001
`endif

// ---- hw/tpu_pkg.sv ----
package tpu_pkg;
  // one apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tpu_apb_s;
  // the whole state of the unit
  typedef struct packed {
    logic [31:0]       tc;
    logic [31:0]       pc;
    logic [31:0]       pr;
    logic [6:0][31:0]  mr;
    logic [6:0][31:0]  sh;
    logic [3:0][31:0]  cap;
    logic [20:0]       mcr;
    logic [11:0]       ccr;
    logic [11:0]       emr;
    logic [14:0]       pcr;
    logic [6:0]        ler;
    logic [11:0]       flags;
    logic [3:0]        ctrl;
    logic [11:0]       csel;
    logic [7:0]        sync1;
    logic [7:0]        sync2;
    logic [3:0]        cprev;
    logic [6:1]        out;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } tpu_state_s;
endpackage

// ---- verif/tpu_load_model.sv ----
`timescale 1ns/1ps
// drive stage load: sees levels only, measures high time and period
module tpu_load_model (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [6:1]       pwm_out,
  output logic      [6:1][15:0] hi_len,
  output logic      [6:1][15:0] per_len
);
  logic [6:1]       prev;    // level one cycle back
  logic [6:1][15:0] hi_run;  // cycles high so far
  logic [6:1][15:0] per_run; // cycles since the last rise
  // lengths settle only after two rises, so the bench waits whole periods
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev    <= '0;
      hi_run  <= '0;
      per_run <= '0;
      hi_len  <= '0;
      per_len <= '0;
    end else begin
      prev <= pwm_out;
      for (int n = 1; n <= 6; n++) begin
        per_run[n] <= (pwm_out[n] && !prev[n]) ? 16'h1 : per_run[n] + 16'h1;
        hi_run[n]  <= (pwm_out[n] && !prev[n]) ? 16'h1 : hi_run[n] + 16'(pwm_out[n]);
        // rising edge closes a period
        if (pwm_out[n] && !prev[n]) begin
          per_len[n] <= per_run[n];
        end
        // falling edge closes a high phase
        if (!pwm_out[n] && prev[n]) begin
          hi_len[n] <= hi_run[n];
        end
      end
    end
  end
endmodule

// ---- verif/test_timer_based_pwm_unit.sv ----
`timescale 1ns/1ps
module test_timer_based_pwm_unit;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic        er;
  } tpu_row_s;
  localparam int TK = 2;          // prescale limit 1: two clocks a tick
  localparam int PER = 10 * TK;   // period match at 9
  localparam int EHI [1:6] = '{4 * TK, 3 * TK, 4 * TK, 9 * TK, 3 * TK, 5 * TK};
  // register rows: address, write data, read back, error
  localparam tpu_row_s ROWS [13] = '{
    '{12'h00c, 32'h1, 32'h1, 1'b0}, '{12'h018, 32'h9, 32'h9, 1'b0},
    '{12'h01c, 32'h3, 32'h3, 1'b0}, '{12'h020, 32'h2, 32'h2, 1'b0},
    '{12'h024, 32'h6, 32'h6, 1'b0}, '{12'h028, 32'h8, 32'h8, 1'b0},
    '{12'h02c, 32'h1, 32'h1, 1'b0}, '{12'h030, 32'h4, 32'h4, 1'b0},
    '{12'h034, 32'hffffffff, 32'hfff, 1'b0}, '{12'h04c, 32'h7e28, 32'h7e28, 1'b0},
    '{12'h100, 32'h5, 32'h0, 1'b1}, '{12'h002, 32'h5, 32'h0, 1'b1},
    '{12'h058, 32'h5, 32'h0, 1'b1}};
  logic              clk;
  logic              rstn;
  tpu_pkg::tpu_apb_s apb;
  logic [7:0]        cap_pin;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [6:1]        pwm_out;
  logic [6:1][15:0]  hi_len;
  logic [6:1][15:0]  per_len;
  int                mismatches;
  int                n_compared;
  logic [31:0]       q;
  logic              e;

  tpu_top dut (.clk(clk), .rstn(rstn), .apb(apb), .cap_pin(cap_pin), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
  tpu_load_model load (.clk(clk), .rstn(rstn), .pwm_out(pwm_out), .hi_len(hi_len),
    .per_len(per_len));

  // 25 MHz clock
  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
    @(posedge clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    // a slave that never answers is caught by the watchdog alone
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, q, e);
  endtask

  // read and compare, bits outside mask ignored
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, q, e);
    chk($sformatf("reg %h", a), q & m, x);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: whole run needs well under 3000 cycles
  initial begin
    #(40 * 6000);
    mismatches++;
    close_out();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    apb = '0;
    cap_pin = 8'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // ordinary rows: write then read back
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      xfer(1'b0, ROWS[i].a, 32'h0, q, e);
      chk($sformatf("row %0d data", i), q, ROWS[i].e);
      chk($sformatf("row %0d error", i), {31'h0, e}, {31'h0, ROWS[i].er});
    end
    // mixed single and double edge outputs sharing one period
    wr(12'h050, 32'h7f);
    wr(12'h004, 32'h9);
    repeat (4 * PER) @(posedge clk);
    for (int n = 1; n <= 6; n++) begin
      chk($sformatf("high %0d", n), {16'h0, hi_len[n]}, EHI[n]);
      chk($sformatf("period %0d", n), {16'h0, per_len[n]}, PER);
    end
    // new match value stays idle until released
    wr(12'h01c, 32'h5);
    repeat (3 * PER) @(posedge clk);
    chk("held high 1", {16'h0, hi_len[1]}, EHI[1]);
    wr(12'h050, 32'h2);
    repeat (3 * PER) @(posedge clk);
    chk("new high 1", {16'h0, hi_len[1]}, 6 * TK);
    rc(12'h050, 32'h7f, 32'h0);
    // plain timer: stop on match 1, flag it, drive external output high
    wr(12'h004, 32'h2);
    wr(12'h014, 32'h28);
    wr(12'h048, 32'h80);
    wr(12'h000, 32'hfff);
    wr(12'h004, 32'h1);
    repeat (40) @(posedge clk);
    chk("pins off", {26'h0, pwm_out}, 32'h0);
    rc(12'h008, 32'hffffffff, 32'h5);
    rc(12'h000, 32'h2, 32'h2);
    rc(12'h048, 32'hff, 32'h82);
    wr(12'h000, 32'h2);
    rc(12'h000, 32'h2, 32'h0);
    // captures: channel 0 single pin, channel 1 two pins and-ed
    wr(12'h054, 32'h20d);
    wr(12'h034, 32'h2d);
    cap_pin <= 8'h01;
    repeat (6) @(posedge clk);
    rc(12'h038, 32'hffffffff, 32'h5);
    rc(12'h000, 32'h100, 32'h100);
    cap_pin <= 8'h05;
    repeat (6) @(posedge clk);
    rc(12'h03c, 32'hffffffff, 32'h0);
    cap_pin <= 8'h0d;
    repeat (6) @(posedge clk);
    rc(12'h03c, 32'hffffffff, 32'h5);
    rc(12'h000, 32'h200, 32'h200);
    // resume at 5: match 1 drives its output low, match 0 resets, match 2
    // toggles its output and stops the counter on 2
    wr(12'h048, 32'h342);
    wr(12'h014, 32'h102);
    wr(12'h004, 32'h1);
    repeat (30) @(posedge clk);
    rc(12'h048, 32'hf, 32'h4);
    rc(12'h008, 32'hffffffff, 32'h2);
    // second reset in mid-run clears all and keeps counting off
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    chk("pins reset", {26'h0, pwm_out}, 32'h0);
    foreach (ROWS[i]) begin
      if (!ROWS[i].er) rc(ROWS[i].a, 32'hffffffff, 32'h0);
    end
    rc(12'h004, 32'hffffffff, 32'h0);
    rc(12'h008, 32'hffffffff, 32'h0);
    close_out();
  end
endmodule
